/* File: common/dioxm_pkg.sv */
// Package for the discrete input conditioner and fault output mapper.
// Assumes one 10 MHz clock and a synchronous active-high reset.
package dioxm_pkg;
    localparam int DIOXM_NUM_IN = 3;
    localparam int DIOXM_NUM_SRC = 27;
    localparam int DIOXM_NUM_SETS = 4;
    localparam int DIOXM_SET_W = 2;
    localparam logic DIOXM_POL_HIGH = 1'h1;
    localparam logic DIOXM_POL_LOW = 1'h0;
    localparam logic DIOXM_SENSE_OPEN = 1'h1;
    localparam logic DIOXM_SENSE_CLOSED = 1'h0;
    localparam logic DIOXM_DRV_HIGH_SIDE = 1'h1;
    localparam logic DIOXM_DRV_LOW_SIDE = 1'h0;
    localparam logic DIOXM_NORM_ON = 1'h1;
    localparam logic DIOXM_NORM_OFF = 1'h0;
    localparam logic [DIOXM_NUM_IN-1:0] DIOXM_POL_RST = 3'h0;
    localparam logic [DIOXM_NUM_IN-1:0] DIOXM_SENSE_RST = 3'h0;
    localparam logic [DIOXM_SET_W-1:0] DIOXM_SEL_HIGH_RST = 2'h2;
    localparam logic [DIOXM_SET_W-1:0] DIOXM_SEL_LOW_RST = 2'h1;
    localparam logic [DIOXM_SET_W-1:0] DIOXM_UNIT1 = 2'h0;
    localparam logic [DIOXM_SET_W-1:0] DIOXM_UNIT2 = 2'h1;
    localparam logic [DIOXM_SET_W-1:0] DIOXM_UNIT3 = 2'h2;
    localparam logic [DIOXM_SET_W-1:0] DIOXM_UNIT4 = 2'h3;

    // Source bit positions in the selection mask
    typedef enum logic [4:0] {
        DIOXM_SRC_ANY_ALARM, DIOXM_SRC_ANY_SHUTDOWN, DIOXM_SRC_BATT_HIGH, DIOXM_SRC_BATT_LOW,
        DIOXM_SRC_RUN_STOP, DIOXM_SRC_LOSS_DMD, DIOXM_SRC_POS_ERR, DIOXM_SRC_TRACK_ERR,
        DIOXM_SRC_ANA_HIGH, DIOXM_SRC_ANA_LOW, DIOXM_SRC_PWM_HIGH, DIOXM_SRC_PWM_LOW,
        DIOXM_SRC_FREQ_HIGH, DIOXM_SRC_FREQ_LOW, DIOXM_SRC_BUS_FAULT, DIOXM_SRC_ADDR_CLAIM,
        DIOXM_SRC_BUS_DMD, DIOXM_SRC_BUS_STOP, DIOXM_SRC_HIGH_TEMP, DIOXM_SRC_TORQ_DERATE,
        DIOXM_SRC_ZERO_TORQ, DIOXM_SRC_TEMP_SENS, DIOXM_SRC_PWRUP_RST, DIOXM_SRC_WDOG_RST,
        DIOXM_SRC_POS_SENS, DIOXM_SRC_NV_MEM, DIOXM_SRC_INT_VOLT
    } dioxm_src_t;

    typedef struct packed {
        logic [DIOXM_NUM_IN-1:0] polarity;
        logic [DIOXM_NUM_IN-1:0] sense;
        logic [DIOXM_SET_W-1:0] sel_high;
        logic [DIOXM_SET_W-1:0] sel_low;
        logic harness_en;
    } dioxm_in_cfg_t;

    typedef struct packed {
        logic drive_type;
        logic norm_mode;
        logic [DIOXM_NUM_SRC-1:0] select;
        logic [DIOXM_NUM_SRC-1:0] used;
    } dioxm_out_cfg_t;
endpackage : dioxm_pkg

/* File: hw/dioxm_in_cond.sv */
// Per-input polarity and contact-sense conditioning.
// Assumes raw inputs are already synchronous to clk_in.
`timescale 1ns/1ps
module dioxm_in_cond (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic [dioxm_pkg::DIOXM_NUM_IN-1:0] raw_in,
    input wire logic [dioxm_pkg::DIOXM_NUM_IN-1:0] polarity_in,
    input wire logic [dioxm_pkg::DIOXM_NUM_IN-1:0] sense_in,
    output logic [dioxm_pkg::DIOXM_NUM_IN-1:0] on_out
);
    import dioxm_pkg::*;
    logic [DIOXM_NUM_IN-1:0] on_ff;
    logic [DIOXM_NUM_IN-1:0] nxt_on;

    genvar g;
    generate
        for (g = 0; g < DIOXM_NUM_IN; g++) begin : g_in
            // Two independent inversions: polarity then sense
            always_comb begin
                nxt_on[g] = (raw_in[g] ~^ polarity_in[g]) ^ sense_in[g]; // [RULE_02] [RULE_03] [RULE_04]
            end
        end
    endgenerate

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            on_ff <= '0;
        end else begin
            on_ff <= nxt_on;
        end
    end
    assign on_out = on_ff;

    // First edge after reset still shows the cleared flops
    cond_a: assert property (@(posedge clk_in) disable iff (rst_in) // [RULE_04]
        !$past(rst_in) |-> on_ff == (($past(raw_in) ~^ $past(polarity_in)) ^ $past(sense_in)))
        else $error("input conditioning mismatch");
endmodule : dioxm_in_cond

/* File: hw/dioxm_top.sv */
// Discrete input conditioner, power-up unit identity and fault output mapper.
// Assumes synchronous inputs and configuration held steady by software.
//
// How it works
// RULE_01: Identity inputs sampled once after power-up.
// RULE_02: Each input polarity selectable, default active-low.
// RULE_03: Each input contact sense selectable, default closed.
// RULE_04: Polarity then sense, each an inversion.
// RULE_05: Output drive type low/high side, default low.
// RULE_06: Normally-on output turns off on condition.
// RULE_07: Condition is OR of selected sources.
// RULE_08: Mask offers the listed fault sources.
// RULE_09: Unused diagnostics cannot drive the output.
// RULE_10: Configuring party should prefer normally-on mode.
// RULE_11: Harness coding selects one of four sets.
// RULE_12: Unit number decoded from high/low identity.
`timescale 1ns/1ps
module dioxm_top (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic [dioxm_pkg::DIOXM_NUM_IN-1:0] din_raw_in,
    input wire dioxm_pkg::dioxm_in_cfg_t in_cfg_in,
    input wire dioxm_pkg::dioxm_out_cfg_t out_cfg_in,
    input wire logic [dioxm_pkg::DIOXM_NUM_SRC-1:0] src_active_in,
    output logic [dioxm_pkg::DIOXM_NUM_IN-1:0] din_on_out,
    output logic [dioxm_pkg::DIOXM_SET_W-1:0] unit_num_out,
    output logic [dioxm_pkg::DIOXM_SET_W-1:0] cfg_set_out,
    output logic id_valid_out,
    output logic dout_on_out,
    output logic dout_low_drv_out,
    output logic dout_high_drv_out,
    output logic src_cond_out
);
    import dioxm_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Input conditioning
    logic [DIOXM_NUM_IN-1:0] on_w;
    dioxm_in_cond u_cond (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .raw_in(din_raw_in),
        .polarity_in(in_cfg_in.polarity),
        .sense_in(in_cfg_in.sense),
        .on_out(on_w)
    );
    assign din_on_out = on_w;

    ////////////////////////////////////////////////////////////////////////////
    // Power-up identity capture
    typedef enum logic [1:0] {DIOXM_ID_WAIT, DIOXM_ID_CAPTURE, DIOXM_ID_LOCKED} dioxm_id_st_t;
    dioxm_id_st_t id_st_ff, nxt_id_st;
    logic [DIOXM_SET_W-1:0] unit_ff, nxt_unit;
    logic harness_ff, nxt_harness;
    logic [DIOXM_SET_W-1:0] set_ff, nxt_set;
    logic valid_ff, nxt_valid;
    logic id_hi, id_lo;

    always_comb begin
        id_hi = on_w[in_cfg_in.sel_high];
        id_lo = on_w[in_cfg_in.sel_low];
        nxt_id_st = id_st_ff;
        nxt_unit = unit_ff;
        nxt_harness = harness_ff;
        case (id_st_ff)
            // One cycle lets the conditioned inputs settle after reset
            DIOXM_ID_WAIT: nxt_id_st = DIOXM_ID_CAPTURE;
            DIOXM_ID_CAPTURE: begin
                nxt_harness = in_cfg_in.harness_en; // [RULE_01]
                case ({id_hi, id_lo}) // [RULE_12]
                    2'h0: nxt_unit = DIOXM_UNIT1;
                    2'h1: nxt_unit = DIOXM_UNIT2;
                    2'h2: nxt_unit = DIOXM_UNIT3;
                    default: nxt_unit = DIOXM_UNIT4;
                endcase
                nxt_id_st = DIOXM_ID_LOCKED; // [RULE_01]
            end
            DIOXM_ID_LOCKED: nxt_id_st = DIOXM_ID_LOCKED;
            default: nxt_id_st = DIOXM_ID_WAIT;
        endcase
        // Registered copies of the active set and capture flag
        nxt_set = nxt_harness ? nxt_unit : DIOXM_UNIT1; // [RULE_11]
        nxt_valid = (nxt_id_st == DIOXM_ID_LOCKED); // [RULE_01]
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            id_st_ff <= DIOXM_ID_WAIT;
            unit_ff <= DIOXM_UNIT1;
            harness_ff <= 1'h0;
            set_ff <= DIOXM_UNIT1;
            valid_ff <= 1'h0;
        end else begin
            id_st_ff <= nxt_id_st;
            unit_ff <= nxt_unit;
            harness_ff <= nxt_harness;
            set_ff <= nxt_set;
            valid_ff <= nxt_valid;
        end
    end

    assign unit_num_out = unit_ff;
    assign id_valid_out = valid_ff;
    assign cfg_set_out = set_ff;

    ////////////////////////////////////////////////////////////////////////////
    // Discrete output mapping
    logic cond_ff, nxt_cond;
    logic dout_ff, nxt_dout;
    logic low_ff, nxt_low;
    logic high_ff, nxt_high;

    always_comb begin
        nxt_cond = |(src_active_in & out_cfg_in.select & out_cfg_in.used); // [RULE_07] [RULE_08] [RULE_09]
        nxt_dout = (out_cfg_in.norm_mode == DIOXM_NORM_ON) ? ~nxt_cond : nxt_cond; // [RULE_06]
        nxt_low = nxt_dout & (out_cfg_in.drive_type == DIOXM_DRV_LOW_SIDE); // [RULE_05]
        nxt_high = nxt_dout & (out_cfg_in.drive_type == DIOXM_DRV_HIGH_SIDE); // [RULE_05]
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            cond_ff <= 1'h0;
            dout_ff <= 1'h0;
            low_ff <= 1'h0;
            high_ff <= 1'h0;
        end else begin
            cond_ff <= nxt_cond;
            dout_ff <= nxt_dout;
            low_ff <= nxt_low;
            high_ff <= nxt_high;
        end
    end

    assign src_cond_out = cond_ff;
    assign dout_on_out = dout_ff;
    assign dout_low_drv_out = low_ff;
    assign dout_high_drv_out = high_ff;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    sequence rst_release_s;
        $fell(rst_in);
    endsequence

    sequence id_captured_s;
        id_st_ff == DIOXM_ID_LOCKED;
    endsequence

    sequence id_steps_s;
        id_st_ff == DIOXM_ID_WAIT ##1 id_st_ff == DIOXM_ID_CAPTURE ##1 id_st_ff == DIOXM_ID_LOCKED;
    endsequence

    // Identity capture
    id_lock_hold_a: assert property (@(posedge clk_in) disable iff (rst_in) // [RULE_01]
        id_captured_s |=> $stable(unit_ff) && $stable(harness_ff) && $stable(cfg_set_out) && id_valid_out)
        else $error("unit id changed after capture");
    id_lock_time_a: assert property (@(posedge clk_in) disable iff (rst_in) // [RULE_01]
        $rose(!rst_in) |-> ##[0:2] id_valid_out)
        else $error("unit id not captured in time");
    id_steps_a: assert property (@(posedge clk_in) disable iff (rst_in) // [RULE_01]
        rst_release_s |-> id_steps_s)
        else $error("identity capture steps out of order");
    id_blank_a: assert property (@(posedge clk_in) disable iff (rst_in) // [RULE_01]
        rst_release_s |-> unit_num_out == DIOXM_UNIT1 && cfg_set_out == DIOXM_UNIT1 && !id_valid_out)
        else $error("unit id visible before capture");
    unit_decode_a: assert property (@(posedge clk_in) disable iff (rst_in) // [RULE_12]
        id_st_ff == DIOXM_ID_CAPTURE |=> unit_ff == {$past(id_hi), $past(id_lo)})
        else $error("unit decode wrong");
    set_select_a: assert property (@(posedge clk_in) disable iff (rst_in) // [RULE_11]
        !harness_ff |-> cfg_set_out == DIOXM_UNIT1)
        else $error("single set not used");
    harness_set_a: assert property (@(posedge clk_in) disable iff (rst_in) // [RULE_11]
        harness_ff |-> cfg_set_out == unit_ff)
        else $error("per-unit set not used");

    // Output sense
    norm_on_a: assert property (@(posedge clk_in) disable iff (rst_in) // [RULE_06]
        out_cfg_in.norm_mode == DIOXM_NORM_ON && !(|(src_active_in & out_cfg_in.select & out_cfg_in.used))
        |=> dout_on_out)
        else $error("normally-on output not on");
    norm_off_a: assert property (@(posedge clk_in) disable iff (rst_in) // [RULE_06]
        out_cfg_in.norm_mode == DIOXM_NORM_OFF && !(|(src_active_in & out_cfg_in.select & out_cfg_in.used))
        |=> !dout_on_out)
        else $error("normally-off output not off");
    cond_on_a: assert property (@(posedge clk_in) disable iff (rst_in) // [RULE_06]
        out_cfg_in.norm_mode == DIOXM_NORM_ON && |(src_active_in & out_cfg_in.select & out_cfg_in.used)
        |=> !dout_on_out)
        else $error("normally-on output not off on fault");
    cond_off_a: assert property (@(posedge clk_in) disable iff (rst_in) // [RULE_06]
        out_cfg_in.norm_mode == DIOXM_NORM_OFF && |(src_active_in & out_cfg_in.select & out_cfg_in.used)
        |=> dout_on_out)
        else $error("normally-off output not on on fault");
    cond_sense_a: assert property (@(posedge clk_in) disable iff (rst_in) // [RULE_06]
        !$past(rst_in) |-> dout_on_out == (($past(out_cfg_in.norm_mode) == DIOXM_NORM_ON) ^ src_cond_out))
        else $error("output sense disagrees with condition");

    // Source selection
    or_source_a: assert property (@(posedge clk_in) disable iff (rst_in) // [RULE_07]
        |(src_active_in & out_cfg_in.select & out_cfg_in.used) |=> src_cond_out)
        else $error("selected source missed");
    unused_block_a: assert property (@(posedge clk_in) disable iff (rst_in) // [RULE_09]
        (src_active_in & out_cfg_in.select & out_cfg_in.used) == '0 |=> !src_cond_out)
        else $error("unused source drove output");

    genvar s;
    generate
        for (s = 0; s < DIOXM_NUM_SRC; s++) begin : g_src
            src_pick_a: assert property (@(posedge clk_in) disable iff (rst_in) // [RULE_08]
                src_active_in[s] && out_cfg_in.select[s] && out_cfg_in.used[s] |=> src_cond_out)
                else $error("listed source did not reach output");
        end
    endgenerate

    // Drive side
    drive_side_a: assert property (@(posedge clk_in) disable iff (rst_in) // [RULE_05]
        !(dout_low_drv_out && dout_high_drv_out) && (dout_on_out == (dout_low_drv_out | dout_high_drv_out)))
        else $error("drive side mismatch");
    low_side_a: assert property (@(posedge clk_in) disable iff (rst_in) // [RULE_05]
        out_cfg_in.drive_type == DIOXM_DRV_LOW_SIDE |=> !dout_high_drv_out && dout_low_drv_out == dout_on_out)
        else $error("low-side drive not used");
    high_side_a: assert property (@(posedge clk_in) disable iff (rst_in) // [RULE_05]
        out_cfg_in.drive_type == DIOXM_DRV_HIGH_SIDE |=> !dout_low_drv_out && dout_high_drv_out == dout_on_out)
        else $error("high-side drive not used");
endmodule : dioxm_top

/* File: sim/dioxm_partner.sv */
// Far-side model: three switch contacts and the monitored output load.
// Assumes wiring sense of each contact matches the polarity setting.
`timescale 1ns/1ps
module dioxm_partner (
    input wire logic [dioxm_pkg::DIOXM_NUM_IN-1:0] wire_high_in,
    input wire logic [dioxm_pkg::DIOXM_NUM_IN-1:0] closed_in,
    input wire logic low_drv_in,
    input wire logic high_drv_in,
    output logic [dioxm_pkg::DIOXM_NUM_IN-1:0] level_out,
    output logic energized_out
);
    import dioxm_pkg::*;
    // Open contact leaves the line at its pull level
    assign level_out = (wire_high_in & closed_in) | (~wire_high_in & ~closed_in);
    assign energized_out = low_drv_in | high_drv_in;
endmodule : dioxm_partner

/* File: sim/dioxm_top_tb_top.sv */
// Self-checking bench for the discrete input and fault output mapper.
// Assumes the design package and the far-side model are compiled first.
`timescale 1ns/1ps
module dioxm_top_tb_top;
    import dioxm_pkg::*;
    localparam logic [DIOXM_NUM_SRC-1:0] ONE = 27'h1;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic [DIOXM_NUM_IN-1:0] closed = 3'h0;
    logic [DIOXM_NUM_IN-1:0] raw;
    logic [DIOXM_NUM_SRC-1:0] src = '0;
    dioxm_in_cfg_t in_cfg = '{polarity: DIOXM_POL_RST, sense: DIOXM_SENSE_RST, sel_high: DIOXM_SEL_HIGH_RST,
                             sel_low: DIOXM_SEL_LOW_RST, harness_en: 1'b1};
    dioxm_out_cfg_t out_cfg = '{drive_type: DIOXM_DRV_LOW_SIDE, norm_mode: DIOXM_NORM_ON, select: '0, used: '1};
    logic [DIOXM_NUM_IN-1:0] on_w;
    logic [DIOXM_SET_W-1:0] unit_w, set_w;
    logic idv_w, don_w, lowd_w, highd_w, cond_w, load_w;
    int n_fail = 0;
    int total_checks = 0;
    initial begin
        forever #50 clk_in = ~clk_in;
    end
    dioxm_partner far (.wire_high_in(in_cfg.polarity), .closed_in(closed), .low_drv_in(lowd_w),
                       .high_drv_in(highd_w), .level_out(raw), .energized_out(load_w));
    dioxm_top dut (.clk_in(clk_in), .rst_in(rst_in), .din_raw_in(raw), .in_cfg_in(in_cfg), .out_cfg_in(out_cfg),
                   .src_active_in(src), .din_on_out(on_w), .unit_num_out(unit_w), .cfg_set_out(set_w),
                   .id_valid_out(idv_w), .dout_on_out(don_w), .dout_low_drv_out(lowd_w),
                   .dout_high_drv_out(highd_w), .src_cond_out(cond_w));
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
        end
    endtask : chk
    task automatic close_out();
        $display("Comparisons %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : close_out
    task automatic power_up();
        @(negedge clk_in);
        rst_in = 1'b1;
        repeat (8) @(negedge clk_in);
        rst_in = 1'b0;
        repeat (3) @(negedge clk_in);
    endtask : power_up
    task automatic out_case(input int m, input logic [26:0] sel, input logic [26:0] usd, input logic [26:0] act,
                            input logic exp);
        logic on_e;
        @(negedge clk_in);
        out_cfg = '{drive_type: m[1], norm_mode: m[0], select: sel, used: usd};
        src = act;
        @(negedge clk_in);
        on_e = m[0] ? ~exp : exp;
        chk("src_cond", {31'h0, exp}, {31'h0, cond_w});
        chk("dout_on", {31'h0, on_e}, {31'h0, don_w});
        chk("low_drv", {31'h0, on_e & ~m[1]}, {31'h0, lowd_w});
        chk("high_drv", {31'h0, on_e & m[1]}, {31'h0, highd_w});
        chk("load", {31'h0, on_e}, {31'h0, load_w});
    endtask : out_case
    initial begin
        repeat (20000) @(posedge clk_in);
        n_fail++;
        close_out();
    end
    initial begin
        ////////////////////////////////////////////////////////////////
        // Identity captured once, all four units, harness on and off
        for (int u = 0; u < 4; u++) begin
            in_cfg.harness_en = (u != 1);
            closed = {u[1], u[0], ~u[0]};
            power_up();
            chk("unit_num", u, {30'h0, unit_w});
            chk("cfg_set", (u != 1) ? u : 0, {30'h0, set_w});
            chk("id_valid", 1, {31'h0, idv_w});
            closed = ~closed;
            in_cfg.harness_en = ~in_cfg.harness_en;
            in_cfg.sel_low = 2'h0;
            repeat (4) @(negedge clk_in);
            chk("unit_hold", u, {30'h0, unit_w});
            chk("set_hold", (u != 1) ? u : 0, {30'h0, set_w});
            in_cfg.sel_low = DIOXM_SEL_LOW_RST;
        end
        $display("Test identity done");
        ////////////////////////////////////////////////////////////////
        // Every polarity and sense combination, contacts taken from k[4:2]
        for (int k = 0; k < 64; k++) begin
            @(negedge clk_in);
            in_cfg.polarity = k[2:0];
            in_cfg.sense = k[5:3];
            closed = k[4:2];
            @(negedge clk_in);
            chk("din_on", {29'h0, k[5:3] ^ k[4:2]}, {29'h0, on_w});
        end
        $display("Test conditioning done");
        ////////////////////////////////////////////////////////////////
        // Each source: selected, inactive while the active others are unselected, unused
        for (int s = 0; s < DIOXM_NUM_SRC; s++) begin
            out_case(s % 4, ONE << s, '1, ONE << s, 1'b1);
            out_case((s + 1) % 4, ONE << s, '1, ~(ONE << s), 1'b0);
            out_case((s + 2) % 4, '1, ~(ONE << s), ONE << s, 1'b0);
        end
        $display("Test output mapping done");
        close_out();
    end
endmodule : dioxm_top_tb_top
